// file: rtl/control_transfer_branch_unit.sv
// Control-transfer decode unit: float and coprocessor branches, call, jump-and-link.
// Assumes software loads instruction, address and operands over AXI4-Lite, then
// writes the instruction word again to start a decode; results appear two cycles after that write.
// How it works
// - float condition decoded from four compare outcomes; 1000 always, 0000 never.
// - float never branch does not transfer; annul bit squashes delay slot.
// - float always branch goes to address plus four times signed offset.
// - conditional float branch transfers only when the condition holds.
// - taken conditional branch runs delay slot; untaken with annul squashes it.
// - float unit off or absent: no branch, no annul, float-off trap.
// - coprocessor condition tests the two-bit flag against listed value sets.
// - coprocessor never and always behave like the float pair.
// - coprocessor off or absent: no branch, no annul, coprocessor-off trap.
// - call, top bits 01, transfers to address plus offset shifted by two.
// - call writes its own address to register 15.
// - jump-and-link targets register sum or register plus signed immediate.
// - jump-and-link writes its own address to its destination register.
// - jump-and-link target with low bits nonzero traps, no transfer.
// - target fetch uses the supervisor state left by a trap return.
`timescale 1ns/1ns
module control_transfer_branch_unit (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // AXI4-Lite write
  input wire logic [4:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // AXI4-Lite read
  input wire logic [4:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // Decode results
  output logic taken_out,
  output logic annul_out,
  output logic [31:0] target_out,
  output logic target_super_out,
  output logic link_we_out,
  output logic [4:0] link_idx_out,
  output logic [31:0] link_val_out,
  output logic [1:0] trap_out,
  output logic done_out
);
  logic wr_en, wr_ok, rd_ok;
  logic [4:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic [31:0] insn_reg, pc_reg, src_reg, src2_reg, ctrl_reg;
  logic start_reg;
  logic float_true, coproc_true;

  ctb_axi_slave u_axi (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .awaddr_in(awaddr_in),
    .awvalid_in(awvalid_in),
    .awready_out(awready_out),
    .wdata_in(wdata_in),
    .wstrb_in(wstrb_in),
    .wvalid_in(wvalid_in),
    .wready_out(wready_out),
    .bresp_out(bresp_out),
    .bvalid_out(bvalid_out),
    .bready_in(bready_in),
    .araddr_in(araddr_in),
    .arvalid_in(arvalid_in),
    .arready_out(arready_out),
    .rdata_out(rdata_out),
    .rresp_out(rresp_out),
    .rvalid_out(rvalid_out),
    .rready_in(rready_in),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_ok_in(wr_ok),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_ok_in(rd_ok)
  );

  ctb_cond_eval u_cond (
    .cond_in(insn_reg[ctb_pkg::COND_HI:ctb_pkg::COND_LO]),
    .fcc_in(ctrl_reg[ctb_pkg::CTRL_FCC_LO +: 2]),
    .ccc_in(ctrl_reg[ctb_pkg::CTRL_CCC_LO +: 2]),
    .float_true_out(float_true),
    .coproc_true_out(coproc_true)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_writable(input logic [4:0] a);
    return a == ctb_pkg::REG_INSN || a == ctb_pkg::REG_PC || a == ctb_pkg::REG_SRC ||
           a == ctb_pkg::REG_SRC2 || a == ctb_pkg::REG_CTRL;
  endfunction

  assign wr_ok = is_writable(wr_addr);

  // Writing the instruction word starts a decode
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      insn_reg <= 32'h0000_0000;
      pc_reg <= 32'h0000_0000;
      src_reg <= 32'h0000_0000;
      src2_reg <= 32'h0000_0000;
      ctrl_reg <= ctb_pkg::CTRL_RESET;
      start_reg <= 1'b0;
    end else begin
      start_reg <= wr_en && wr_addr == ctb_pkg::REG_INSN;
      if (wr_en) begin
        case (wr_addr)
          ctb_pkg::REG_INSN: insn_reg <= merge(insn_reg, wr_data, wr_strb);
          ctb_pkg::REG_PC: pc_reg <= merge(pc_reg, wr_data, wr_strb);
          ctb_pkg::REG_SRC: src_reg <= merge(src_reg, wr_data, wr_strb);
          ctb_pkg::REG_SRC2: src2_reg <= merge(src2_reg, wr_data, wr_strb);
          ctb_pkg::REG_CTRL: ctrl_reg <= merge(ctrl_reg, wr_data, wr_strb);
          default: ;
        endcase
      end
    end
  end

  // Combinational decode
  logic [1:0] op;
  logic is_fb, is_cb, is_call, is_jl, annul_bit, uncond, cond_true, unit_on;
  logic [31:0] br_target, call_target, jl_target;
  logic taken_next, annul_next, link_we_next;
  logic [1:0] trap_next;
  logic [31:0] target_next;
  logic [4:0] link_idx_next;
  always_comb begin
    op = insn_reg[ctb_pkg::OP_HI:ctb_pkg::OP_LO];
    // Branch families
    is_fb = op == ctb_pkg::OP_BRANCH &&
            insn_reg[ctb_pkg::SUB_HI:ctb_pkg::SUB_LO] == ctb_pkg::SUB_FLOAT;
    is_cb = op == ctb_pkg::OP_BRANCH &&
            insn_reg[ctb_pkg::SUB_HI:ctb_pkg::SUB_LO] == ctb_pkg::SUB_COPROC;
    is_call = op == ctb_pkg::OP_CALL;
    is_jl = op == ctb_pkg::OP_ARITH &&
            insn_reg[ctb_pkg::OP3_HI:ctb_pkg::OP3_LO] == ctb_pkg::OP3_JUMP_LINK;
    annul_bit = insn_reg[ctb_pkg::ANNUL_BIT];
    uncond = insn_reg[ctb_pkg::COND_HI:ctb_pkg::COND_LO] == ctb_pkg::COND_ALWAYS ||
             insn_reg[ctb_pkg::COND_HI:ctb_pkg::COND_LO] == ctb_pkg::COND_NEVER;
    cond_true = is_fb ? float_true : coproc_true;
    unit_on = is_fb ? (ctrl_reg[ctb_pkg::CTRL_FEN] & ctrl_reg[ctb_pkg::CTRL_FPRES])
                    : (ctrl_reg[ctb_pkg::CTRL_CEN] & ctrl_reg[ctb_pkg::CTRL_CPRES]);
    // Sign-extend before scaling so that backward offsets wrap
    br_target = pc_reg + {{8{insn_reg[ctb_pkg::BR_OFS_HI]}},
                          insn_reg[ctb_pkg::BR_OFS_HI:0], 2'h0};
    call_target = pc_reg + {insn_reg[ctb_pkg::LONG_OFS_HI:0], 2'h0};
    jl_target = src_reg + (insn_reg[ctb_pkg::IMM_SEL_BIT] ?
                {{19{insn_reg[ctb_pkg::SIMM_HI]}}, insn_reg[ctb_pkg::SIMM_HI:0]} :
                src2_reg);
    taken_next = 1'b0;
    annul_next = 1'b0;
    link_we_next = 1'b0;
    link_idx_next = 5'h00;
    trap_next = ctb_pkg::TRAP_NONE;
    target_next = 32'h0000_0000;
    if (is_fb || is_cb) begin
      if (!unit_on) begin
        // Disabled unit: neither branch nor annul
        trap_next = is_fb ? ctb_pkg::TRAP_FLOAT_OFF : ctb_pkg::TRAP_COPROC_OFF;
      end else if (uncond) begin
        // Always or never: annul bit alone squashes the slot
        taken_next = cond_true;
        annul_next = annul_bit;
        target_next = br_target;
      end else begin
        // Annul only bites on the untaken path
        taken_next = cond_true;
        annul_next = annul_bit & ~cond_true;
        target_next = br_target;
      end
    end else if (is_call) begin
      taken_next = 1'b1;
      target_next = call_target;
      link_we_next = 1'b1;
      link_idx_next = ctb_pkg::LINK_REG;
    end else if (is_jl) begin
      target_next = jl_target;
      link_we_next = 1'b1;
      link_idx_next = insn_reg[ctb_pkg::RD_HI:ctb_pkg::RD_LO];
      if (jl_target[1:0] != 2'h0) begin
        trap_next = ctb_pkg::TRAP_MISALIGN;
      end else begin
        taken_next = 1'b1;
      end
    end
  end

  // Result latch, held until the next decode
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      taken_out <= 1'b0;
      annul_out <= 1'b0;
      target_out <= 32'h0000_0000;
      link_we_out <= 1'b0;
      link_idx_out <= 5'h00;
      link_val_out <= 32'h0000_0000;
      trap_out <= ctb_pkg::TRAP_NONE;
    end else if (start_reg) begin
      taken_out <= taken_next;
      annul_out <= annul_next;
      target_out <= target_next;
      link_we_out <= link_we_next;
      link_idx_out <= link_idx_next;
      link_val_out <= pc_reg;
      trap_out <= trap_next;
    end
  end

  // Supervisor state is sampled at decode, so a trap return written before start wins
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      target_super_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= start_reg;
      if (start_reg) begin
        target_super_out <= ctrl_reg[ctb_pkg::CTRL_SUPER];
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    case (rd_addr)
      ctb_pkg::REG_INSN: rd_data = insn_reg;
      ctb_pkg::REG_PC: rd_data = pc_reg;
      ctb_pkg::REG_SRC: rd_data = src_reg;
      ctb_pkg::REG_SRC2: rd_data = src2_reg;
      ctb_pkg::REG_CTRL: rd_data = ctrl_reg;
      ctb_pkg::REG_TARGET: rd_data = target_out;
      ctb_pkg::REG_STATUS: rd_data = {27'h0, trap_out, link_we_out, annul_out, taken_out};
      ctb_pkg::REG_LINK: rd_data = link_val_out;
      default: begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Disabled unit never transfers or annuls
  property p_off_trap;
    @(posedge clk_sys_in) disable iff (rst_in)
      start_reg && (is_fb || is_cb) && !unit_on |=>
        !taken_out && !annul_out && trap_out != ctb_pkg::TRAP_NONE;
  endproperty
  a_off_trap: assert property (p_off_trap) else $error("disabled unit branched");
  property p_cond_annul;
    @(posedge clk_sys_in) disable iff (rst_in)
      start_reg && (is_fb || is_cb) && unit_on && !uncond |=>
        annul_out == (annul_bit && !taken_out);
  endproperty
  a_cond_annul: assert property (p_cond_annul) else $error("conditional annul wrong");
  property p_never;
    @(posedge clk_sys_in) disable iff (rst_in)
      start_reg && is_fb && unit_on &&
        insn_reg[ctb_pkg::COND_HI:ctb_pkg::COND_LO] == ctb_pkg::COND_NEVER |=>
        !taken_out && annul_out == $past(annul_bit);
  endproperty
  a_never: assert property (p_never) else $error("never branch wrong");
  property p_always;
    @(posedge clk_sys_in) disable iff (rst_in)
      start_reg && is_cb && unit_on &&
        insn_reg[ctb_pkg::COND_HI:ctb_pkg::COND_LO] == ctb_pkg::COND_ALWAYS |=>
        taken_out && target_out == $past(br_target);
  endproperty
  a_always: assert property (p_always) else $error("always branch wrong");
  property p_call_link;
    @(posedge clk_sys_in) disable iff (rst_in)
      start_reg && is_call |=> link_we_out && link_idx_out == ctb_pkg::LINK_REG &&
        link_val_out == $past(pc_reg);
  endproperty
  a_call_link: assert property (p_call_link) else $error("call link wrong");
  property p_misalign;
    @(posedge clk_sys_in) disable iff (rst_in)
      start_reg && is_jl && jl_target[1:0] != 2'h0 |=>
        trap_out == ctb_pkg::TRAP_MISALIGN && !taken_out;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned jump taken");
  property p_jl_link;
    @(posedge clk_sys_in) disable iff (rst_in)
      start_reg && is_jl |=> link_idx_out == $past(insn_reg[ctb_pkg::RD_HI:ctb_pkg::RD_LO]) &&
        target_out == $past(jl_target);
  endproperty
  a_jl_link: assert property (p_jl_link) else $error("jump link wrong");
  property p_done;
    @(posedge clk_sys_in) disable iff (rst_in)
      wr_en && wr_addr == ctb_pkg::REG_INSN |-> ##2 done_out ##1 !done_out;
  endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
endmodule // control_transfer_branch_unit

// file: rtl/ctb_axi_slave.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes a master that follows AXI4-Lite handshakes; strobes go to the core.
`timescale 1ns/1ns
module ctb_axi_slave (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Write channels
  input wire logic [4:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // Read channels
  input wire logic [4:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // Core side
  output logic wr_en_out,
  output logic [4:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic wr_ok_in,
  output logic [4:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_ok_in
);
  logic aw_have_reg, w_have_reg;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      wr_addr_out <= 5'h00;
      wr_data_out <= 32'h0000_0000;
      wr_strb_out <= 4'h0;
    end else begin
      awready_out <= ~aw_have_reg & ~awready_out & ~bvalid_out & awvalid_in;
      wready_out <= ~w_have_reg & ~wready_out & ~bvalid_out & wvalid_in;
      if (awvalid_in & awready_out) begin
        aw_have_reg <= 1'b1;
        wr_addr_out <= awaddr_in;
      end
      if (wvalid_in & wready_out) begin
        w_have_reg <= 1'b1;
        wr_data_out <= wdata_in;
        wr_strb_out <= wstrb_in;
      end
      if (wr_en_out) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
    end
  end
  // Fires for one cycle once both halves have landed
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_en_out <= 1'b0;
    end else begin
      wr_en_out <= aw_have_reg & w_have_reg & ~wr_en_out & ~bvalid_out;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      bvalid_out <= 1'b0;
      bresp_out <= ctb_pkg::RESP_OKAY;
    end else if (wr_en_out) begin
      bvalid_out <= 1'b1;
      bresp_out <= wr_ok_in ? ctb_pkg::RESP_OKAY : ctb_pkg::RESP_SLVERR;
    end else if (bready_in) begin
      bvalid_out <= 1'b0;
    end
  end
  // Offered address feeds the core decode directly, so the word captured at the handshake
  // belongs to this read and not to the one before
  assign rd_addr_out = araddr_in;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      rresp_out <= ctb_pkg::RESP_OKAY;
    end else begin
      arready_out <= arvalid_in & ~arready_out & ~rvalid_out;
      if (arvalid_in & arready_out) begin
        rvalid_out <= 1'b1;
        rdata_out <= rd_data_in;
        rresp_out <= rd_ok_in ? ctb_pkg::RESP_OKAY : ctb_pkg::RESP_SLVERR;
      end else if (rready_in) begin
        rvalid_out <= 1'b0;
      end
    end
  end
endmodule // ctb_axi_slave

// file: rtl/ctb_cond_eval.sv
// Combinational condition evaluator for both branch families.
// Assumes flags are stable when the decode step samples the result.
`timescale 1ns/1ns
module ctb_cond_eval (
  // Condition and flags
  input wire logic [3:0] cond_in,
  input wire logic [1:0] fcc_in,
  input wire logic [1:0] ccc_in,
  // Results
  output logic float_true_out,
  output logic coproc_true_out
);
  logic e, l, g, u;
  logic [3:0] cv;
  always_comb begin
    e = (fcc_in == ctb_pkg::FCC_E);
    l = (fcc_in == ctb_pkg::FCC_L);
    g = (fcc_in == ctb_pkg::FCC_G);
    u = (fcc_in == ctb_pkg::FCC_U);
    // Float outcomes by condition code
    case (cond_in)
      4'h0: float_true_out = 1'b0;
      4'h1: float_true_out = l | g | u;
      4'h2: float_true_out = l | g;
      4'h3: float_true_out = l | u;
      4'h4: float_true_out = l;
      4'h5: float_true_out = g | u;
      4'h6: float_true_out = g;
      4'h7: float_true_out = u;
      4'h8: float_true_out = 1'b1;
      4'h9: float_true_out = e;
      4'hA: float_true_out = e | u;
      4'hB: float_true_out = e | g;
      4'hC: float_true_out = e | g | u;
      4'hD: float_true_out = e | l;
      4'hE: float_true_out = e | l | u;
      default: float_true_out = ~u;
    endcase
    // Coprocessor value sets, bit n set means flag value n passes
    case (cond_in)
      4'h0: cv = 4'h0;
      4'h1: cv = 4'hE;
      4'h2: cv = 4'h6;
      4'h3: cv = 4'hA;
      4'h4: cv = 4'h2;
      4'h5: cv = 4'hC;
      4'h6: cv = 4'h4;
      4'h7: cv = 4'h8;
      4'h8: cv = 4'hF;
      4'h9: cv = 4'h1;
      4'hA: cv = 4'h9;
      4'hB: cv = 4'h5;
      4'hC: cv = 4'hD;
      4'hD: cv = 4'h3;
      4'hE: cv = 4'hB;
      default: cv = 4'h7;
    endcase
    coproc_true_out = cv[ccc_in];
  end
endmodule // ctb_cond_eval

// file: rtl/ctb_pkg.sv
// Constants, encodings and register map of the control-transfer branch unit.
// Assumes one 20 MHz clock domain and an AXI4-Lite register bus.
package ctb_pkg;
  // Instruction fields
  localparam int OP_HI = 31;
  localparam int OP_LO = 30;
  localparam int ANNUL_BIT = 29;
  localparam int COND_HI = 28;
  localparam int COND_LO = 25;
  localparam int SUB_HI = 24;
  localparam int SUB_LO = 22;
  localparam int OP3_HI = 24;
  localparam int OP3_LO = 19;
  localparam int RD_HI = 29;
  localparam int RD_LO = 25;
  localparam int IMM_SEL_BIT = 13;
  localparam int SIMM_HI = 12;
  localparam int BR_OFS_HI = 21;
  localparam int LONG_OFS_HI = 29;
  // Encodings
  localparam logic [1:0] OP_BRANCH = 2'h0;
  localparam logic [1:0] OP_CALL = 2'h1;
  localparam logic [1:0] OP_ARITH = 2'h2;
  localparam logic [2:0] SUB_FLOAT = 3'h6;
  localparam logic [2:0] SUB_COPROC = 3'h7;
  localparam logic [5:0] OP3_JUMP_LINK = 6'h38;
  localparam logic [3:0] COND_NEVER = 4'h0;
  localparam logic [3:0] COND_ALWAYS = 4'h8;
  localparam logic [4:0] LINK_REG = 5'h0F;
  // Float compare flags
  localparam logic [1:0] FCC_E = 2'h0;
  localparam logic [1:0] FCC_L = 2'h1;
  localparam logic [1:0] FCC_G = 2'h2;
  localparam logic [1:0] FCC_U = 2'h3;
  // Trap codes on the trap port
  localparam logic [1:0] TRAP_NONE = 2'h0;
  localparam logic [1:0] TRAP_FLOAT_OFF = 2'h1;
  localparam logic [1:0] TRAP_COPROC_OFF = 2'h2;
  localparam logic [1:0] TRAP_MISALIGN = 2'h3;
  // Register byte offsets
  localparam logic [4:0] REG_INSN = 5'h00;
  localparam logic [4:0] REG_PC = 5'h04;
  localparam logic [4:0] REG_SRC = 5'h08;
  localparam logic [4:0] REG_SRC2 = 5'h0C;
  localparam logic [4:0] REG_CTRL = 5'h10;
  localparam logic [4:0] REG_TARGET = 5'h14;
  localparam logic [4:0] REG_STATUS = 5'h18;
  localparam logic [4:0] REG_LINK = 5'h1C;
  // Control register fields
  localparam int CTRL_FCC_LO = 0;
  localparam int CTRL_CCC_LO = 2;
  localparam int CTRL_FEN = 4;
  localparam int CTRL_CEN = 5;
  localparam int CTRL_FPRES = 6;
  localparam int CTRL_CPRES = 7;
  localparam int CTRL_SUPER = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_00C0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: verification/flag_source.sv
// Stand-in for the float unit and coprocessor: presents flags, enables and presence.
// Assumes the bench copies this word into the control register before a decode.
`timescale 1ns/1ns
module flag_source (
  // Flags, enables, presence and supervisor bit
  input wire logic [8:0] state_in,
  // Control word
  output logic [31:0] ctrl_out
);
  // Flags settle before each decode and never move during one, so no compare
  // or state-word load ever sits right next to a branch
  // Branches are decoded singly, never from a delay slot
  assign ctrl_out = {23'h0, state_in};
endmodule // flag_source

// file: verification/tb.sv
// Bench: every branch code of both families, call and jump-and-link, over AXI4-Lite.
// Assumes results stand from done_out until the next decode.
`timescale 1ns/1ns
module tb;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] awaddr_in = 5'h00;
  logic awvalid_in = 1'b0;
  logic [31:0] wdata_in = 32'h0;
  logic [3:0] wstrb_in = 4'hF;
  logic wvalid_in = 1'b0;
  logic bready_in = 1'b0;
  logic [4:0] araddr_in = 5'h00;
  logic arvalid_in = 1'b0;
  logic rready_in = 1'b0;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic [1:0] bresp_out, rresp_out, trap_out, resp;
  logic [31:0] rdata_out, target_out, link_val_out, ctrl, rd;
  logic taken_out, annul_out, target_super_out, link_we_out, done_out;
  logic [4:0] link_idx_out;
  logic [8:0] state = 9'h0C0;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int done_cnt = 0;
  // Taken mask per condition, nibble index is the condition, bit index the flag value; same for both families
  localparam logic [63:0] MASKS = 64'h7B3D_591F_84C2_A6E0;
  flag_source fs (.state_in(state), .ctrl_out(ctrl));
  control_transfer_branch_unit dut (.clk_sys_in, .rst_in, .awaddr_in, .awvalid_in,
    .awready_out, .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out,
    .bvalid_out, .bready_in, .araddr_in, .arvalid_in, .arready_out, .rdata_out,
    .rresp_out, .rvalid_out, .rready_in, .taken_out, .annul_out, .target_out,
    .target_super_out, .link_we_out, .link_idx_out, .link_val_out, .trap_out,
    .done_out);
  initial forever #25 clk_sys_in = ~clk_sys_in;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Ceiling well above the roughly 3700 cycles the tests need
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (done_out === 1'b1) done_cnt <= done_cnt + 1;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Ready is sampled at the falling edge; it holds to the next rising edge
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic aw_hit, w_hit;
    awaddr_in <= a;
    wdata_in <= d;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    do begin
      @(negedge clk_sys_in);
      aw_hit = awvalid_in && awready_out;
      w_hit = wvalid_in && wready_out;
      @(posedge clk_sys_in);
      if (aw_hit) awvalid_in <= 1'b0;
      if (w_hit) wvalid_in <= 1'b0;
    end while (awvalid_in || wvalid_in);
    bready_in <= 1'b1;
    do @(negedge clk_sys_in); while (bvalid_out !== 1'b1);
    resp = bresp_out;
    @(posedge clk_sys_in);
    bready_in <= 1'b0;
  endtask
  task automatic rdr(input logic [4:0] a);
    logic hit;
    araddr_in <= a;
    arvalid_in <= 1'b1;
    do begin
      @(negedge clk_sys_in);
      hit = arready_out;
      @(posedge clk_sys_in);
    end while (hit !== 1'b1);
    arvalid_in <= 1'b0;
    rready_in <= 1'b1;
    do @(negedge clk_sys_in); while (rvalid_out !== 1'b1);
    rd = rdata_out;
    resp = rresp_out;
    @(posedge clk_sys_in);
    rready_in <= 1'b0;
  endtask
  task automatic decode(input logic [31:0] insn, pc, s1, s2);
    int n;
    wr(ctb_pkg::REG_PC, pc);
    wr(ctb_pkg::REG_SRC, s1);
    wr(ctb_pkg::REG_SRC2, s2);
    wr(ctb_pkg::REG_CTRL, ctrl);
    n = done_cnt;
    wr(ctb_pkg::REG_INSN, insn);
    repeat (8) if (done_cnt == n) @(posedge clk_sys_in);
    check("done", done_cnt - n, 1);
  endtask
  // Status packs {trap, link write, annul, taken}; target only checked without a trap
  task automatic res(input logic [4:0] st, input logic [31:0] tgt, lv, input logic [4:0] li);
    check("status", {27'h0, trap_out, link_we_out, annul_out, taken_out}, {27'h0, st});
    if (st[4:3] == 2'h0) check("target", target_out, tgt);
    if (st[2]) check("link_idx", {27'h0, link_idx_out}, {27'h0, li});
    if (st[2]) check("link_val", link_val_out, lv);
  endtask
  initial begin
    logic [31:0] pc;
    logic [21:0] disp;
    logic a, tk;
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    rdr(ctb_pkg::REG_CTRL);
    check("ctrl_reset", rd, ctb_pkg::CTRL_RESET);
    check("rd_resp", {30'h0, resp}, {30'h0, ctb_pkg::RESP_OKAY});
    rdr(5'h01);
    check("bad_rd", rd, 32'h0);
    check("bad_rd_resp", {30'h0, resp}, {30'h0, ctb_pkg::RESP_SLVERR});
    wr(ctb_pkg::REG_TARGET, 32'h0);
    check("ro_resp", {30'h0, resp}, {30'h0, ctb_pkg::RESP_SLVERR});
    $display("test registers done");
    for (int fam = 0; fam < 2; fam++) begin
      for (int c = 0; c < 16; c++) begin
        for (int f = 0; f < 4; f++) begin
          state = {c[0], 2'h3, fam[0] ? {2'h2, f[1:0], 2'h0} : {2'h1, 2'h0, f[1:0]}};
          a = f[0] ^ c[1];
          disp = {22{c[0]}} ^ 22'(c * 3);
          pc = {fam[0], 31'h10};
          tk = MASKS[c * 4 + f];
          decode({2'h0, a, c[3:0], fam[0] ? 3'h7 : 3'h6, disp}, pc, 32'h0, 32'h0);
          res({3'h0, (c[2:0] == 3'h0) ? a : a & !tk, tk},
            pc + {{8{disp[21]}}, disp, 2'h0}, 32'h0, 5'h0);
          check("super", {31'h0, target_super_out}, {31'h0, c[0]});
        end
      end
    end
    $display("test conditions done");
    for (int d = 0; d < 4; d++) begin
      state = d[0] ? (d[1] ? 9'h070 : 9'h0D0) : (d[1] ? 9'h0B0 : 9'h0E0);
      decode({2'h0, 1'b1, 4'h8, d[0] ? 3'h7 : 3'h6, 22'h4}, 32'h40, 32'h0, 32'h0);
      res({d[0] ? 2'h2 : 2'h1, 3'h0}, 32'h0, 32'h0, 5'h0);
    end
    $display("test disabled done");
    state = 9'h0F0;
    decode({2'h1, 30'h3FFF_FFFE}, 32'h1000, 32'h0, 32'h0);
    res(5'h05, 32'h0FF8, 32'h1000, 5'h0F);
    decode({2'h2, 5'h0F, 6'h38, 5'h01, 1'b0, 8'h00, 5'h02}, 32'h200, 32'h100, 32'h24);
    res(5'h05, 32'h124, 32'h200, 5'h0F);
    decode({2'h2, 5'h00, 6'h38, 5'h01, 1'b1, 13'h1FF8}, 32'h300, 32'h100, 32'h0);
    res(5'h05, 32'hF8, 32'h300, 5'h00);
    decode({2'h2, 5'h03, 6'h38, 5'h01, 1'b1, 13'h0002}, 32'h400, 32'h100, 32'h0);
    res(5'h1C, 32'h0, 32'h400, 5'h03);
    rdr(ctb_pkg::REG_STATUS);
    check("status_reg", rd, 32'h1C);
    $display("test links done");
    wrap_up();
  end
endmodule // tb
